/* File: dv/acs_host_model.sv */
// Host controller model: drives convert start, serial clock and serial input.
// Assumes the bench calls its tasks just after a core clock rising edge.
`timescale 1ns/10ps
`default_nettype none
module acs_host_model
  import acs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_serial_out_line,
  input wire logic i_serial_out_oe,
  output var acs_pins_t o_pins
);
  initial o_pins = '0;

  task automatic start_conv(input logic mode);
    o_pins.convert_start <= 1'h0;
    repeat (100) @(posedge i_core_clk);
    o_pins.serial_in_line <= mode;
    repeat (2) @(posedge i_core_clk);
    o_pins.convert_start <= 1'h1;
    repeat (25) @(posedge i_core_clk);
    o_pins.convert_start <= 1'h0;
  endtask : start_conv

  task automatic raise_start();
    o_pins.serial_in_line <= 1'h1;
    o_pins.convert_start <= 1'h1;
  endtask : raise_start

  // 160 ns period, data set before rise
  task automatic sbit(input logic din, output logic dout, output logic doe);
    o_pins.serial_in_line <= din;
    repeat (4) @(posedge i_core_clk);
    o_pins.serial_clk <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    dout = i_serial_out_line;
    doe = i_serial_out_oe;
    @(posedge i_core_clk);
    o_pins.serial_clk <= 1'h0;
  endtask : sbit
endmodule : acs_host_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the converter serial timing block.
// Assumes a host model on the pins and a queue model of the output stream.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import acs_pkg::*;
;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [1:0] grade = 2'h0;
  logic [19:0] result = 20'h0;
  logic sout, soe, busy, ready, acq, daisy, cfg_valid;
  logic [15:0] cfg_word, cfg_got;
  acs_pins_t pins;
  logic [31:0] seed = 32'h5E;
  logic q[$];
  int bad_count = 0;
  int samples_checked = 0;
  int bcnt = 0;
  int acnt = 0;
  int cfg_hits = 0;

  always #10 core_clk = ~core_clk;

  acs_core dut (.i_core_clk(core_clk), .i_rstn(rstn), .i_ce(1'h1),
    .i_convert_start(pins.convert_start), .i_serial_clk(pins.serial_clk),
    .i_serial_in_line(pins.serial_in_line), .i_speed_grade(grade),
    .i_conv_result(result), .o_serial_out_line(sout), .o_serial_out_oe(soe),
    .o_conv_busy(busy), .o_data_ready(ready), .o_acq_ready(acq),
    .o_daisy_mode(daisy), .o_cfg_word(cfg_word), .o_cfg_valid(cfg_valid));

  acs_host_model host (.i_core_clk(core_clk), .i_serial_out_line(sout),
    .i_serial_out_oe(soe), .o_pins(pins));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic int acq_exp(input logic [1:0] g);
    return g == 2'h0 ? (325 + 19) / 20 : g == 2'h1 ? (770 + 19) / 20 : (1770 + 19) / 20;
  endfunction : acq_exp

  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic chkw(input logic [19:0] got, input logic [19:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chkw

  task automatic chkc(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chkc

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Conversion length, acquisition count and write pulses
  always @(negedge core_clk) begin
    if (busy === 1'h1) begin
      bcnt++;
    end else if (bcnt != 0) begin
      chkc(bcnt, CONVERSION_TIME_MIN_NS / 20, "busy length");
      chk1(ready, 1'h1, "data ready");
      chk1((bcnt * CLK_PERIOD_NS) < (1000000 / TPUT_TURBO_KSPS), 1'h1, "rate budget");
      bcnt = 0;
    end
    if (acq === 1'h0) begin
      acnt++;
    end else if (acnt != 0) begin
      chkc(acnt, acq_exp(grade), "acquisition");
      acnt = 0;
    end
    if (cfg_valid === 1'h1 && cfg_hits == 0) cfg_got = cfg_word;
    if (cfg_valid === 1'h1) cfg_hits++;
  end

  task automatic run_read(input logic dc, input int nbits, input logic abort);
    logic [31:0] r;
    logic d, o, e;
    logic [15:0] cexp;
    cexp = 16'h0;
    q.delete();
    host.start_conv(~dc);
    cfg_hits = 0;
    chk1(daisy, dc, "mode");
    for (int i = 0; i < 20; i++) q.push_back(result[19 - i]);
    r = xs();
    for (int i = 0; i < nbits; i++) begin
      d = r[i % 32];
      if (i < 16) cexp = {cexp[14:0], d};
      if (dc) q.push_back(d);
      host.sbit(d, o, e);
      chk1(e, 1'h1, "drive");
      chk1(o, q.pop_front(), "bit");
    end
    if (abort) begin
      // Quiet time after the last falling edge
      repeat (3) @(posedge core_clk);
      host.raise_start();
    end
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    if (!dc) chk1(soe, 1'h0, "release");
    chkc(cfg_hits, dc ? 0 : 1, "write count");
    if (!dc) chkw({4'h0, cfg_got}, {4'h0, cexp}, "write word");
  endtask : run_read

  initial begin
    logic [31:0] r;
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    for (int t = 0; t < 8; t++) begin
      r = xs();
      grade <= 2'(t % 4);
      result <= r[19:0];
      run_read(t >= 4, t >= 4 ? 40 : (t == 3 ? 18 : 20), t == 3);
      repeat (110) @(posedge core_clk);
      $display("test %0d done", t);
    end
    stop_test();
  end

  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire

/* File: logic/acs_core.sv */
// Conversion sequencing and serial readout of a 20-bit converter.
// Assumes host pins are asynchronous and sampled by the 50 MHz core clock;
// the analog result arrives on i_conv_result in the core domain.
// Function
// - Finish conversion 300 to 350 ns after start
// - Leave acquisition window per speed grade
// - Chip-select mode releases output on select high or end
// - Select low drives output, MSB first
// - Advance output bit on clock falling edge
// - Daisy-chain mode releases output on start rise
// - Turbo throughput 1.80 or 1.67 MSPS
// - Plain throughput 1.61/1.49, 1.47/1.34 MSPS
// - Serial input level at start picks mode
// - Daisy chain delays input 20 clocks
`timescale 1ns/10ps
`default_nettype none
module acs_core
  import acs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_convert_start,
  input wire logic i_serial_clk,
  input wire logic i_serial_in_line,
  input wire logic [1:0] i_speed_grade,
  input wire logic [RESULT_W-1:0] i_conv_result,
  output logic o_serial_out_line,
  output logic o_serial_out_oe,
  output logic o_conv_busy,
  output logic o_data_ready,
  output logic o_acq_ready,
  output logic o_daisy_mode,
  output logic [CFG_W-1:0] o_cfg_word,
  output logic o_cfg_valid
);

  acs_pins_t pin_async;
  acs_pins_t pin_s;
  acs_pins_t pin_p_q;

  assign pin_async = '{convert_start: i_convert_start, serial_clk: i_serial_clk,
                       serial_in_line: i_serial_in_line};

  acs_sync #(.W($bits(acs_pins_t))) u_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_async(pin_async),
    .o_sync(pin_s)
  );

  acs_state_t state_q;
  logic [4:0] conv_cnt_q;
  logic [6:0] acq_cnt_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic read_done_q;
  logic chain_bit_q;
  logic [CFG_W-1:0] wr_q;
  logic [4:0] wr_cnt_q;

  // Edge detection on synchronised levels
  wire start_rise = pin_s.convert_start & ~pin_p_q.convert_start;
  wire sclk_rise = pin_s.serial_clk & ~pin_p_q.serial_clk;
  wire sclk_fall = ~pin_s.serial_clk & pin_p_q.serial_clk;
  wire idle = (state_q == ST_IDLE);
  wire conv_end = (state_q == ST_CONV) && (conv_cnt_q == CONV_LAST);
  wire cs_select = ~pin_s.convert_start | ~pin_s.serial_in_line;
  wire cs_drive = idle && !o_daisy_mode && cs_select && !read_done_q && !start_rise;
  wire dc_drive = idle && o_daisy_mode && !start_rise;
  wire shift_en = sclk_fall && (cs_drive || dc_drive);
  wire last_bit = shift_en && !o_daisy_mode && (bit_cnt_q == RESULT_LAST);
  wire wr_en = idle && !o_daisy_mode && !pin_s.convert_start && sclk_rise;
  wire [6:0] acq_goal = (i_speed_grade == GRADE_FAST) ? ACQ_FAST_CYC :
                        (i_speed_grade == GRADE_MID) ? ACQ_MID_CYC : ACQ_SLOW_CYC;
  wire [RESULT_W-1:0] shift_next = {shift_q[RESULT_W-2:0], o_daisy_mode & chain_bit_q};

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_p_q <= '0;
    end else if (i_ce) begin
      pin_p_q <= pin_s;
    end
  end

  // Conversion sequencer
  // short fixed conversion
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= 5'h00;
      o_conv_busy <= 1'b0;
      o_data_ready <= 1'b0;
      o_daisy_mode <= 1'b0;
      result_q <= '0;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (start_rise) begin
            o_daisy_mode <= ~pin_s.serial_in_line;
            state_q <= ST_CONV;
            conv_cnt_q <= 5'h00;
            o_conv_busy <= 1'b1;
            o_data_ready <= 1'b0;
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            result_q <= i_conv_result;
            state_q <= ST_IDLE;
            o_conv_busy <= 1'b0;
            o_data_ready <= 1'b1;
          end else begin
            conv_cnt_q <= conv_cnt_q + 5'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acq_cnt_q <= 7'h00;
      o_acq_ready <= 1'b1;
    end else if (i_ce) begin
      if (conv_end) begin
        acq_cnt_q <= 7'h00;
        o_acq_ready <= 1'b0;
      end else if (idle && !o_acq_ready) begin
        acq_cnt_q <= acq_cnt_q + 7'h01;
        o_acq_ready <= (acq_cnt_q + 7'h01 >= acq_goal);
      end
    end
  end

  // Output shifter
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_q <= '0;
      bit_cnt_q <= 5'h00;
      read_done_q <= 1'b1;
      chain_bit_q <= 1'b0;
      o_serial_out_line <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else if (i_ce) begin
      // chain data captured on rising edge
      if (sclk_rise) begin
        chain_bit_q <= pin_s.serial_in_line;
      end
      if (conv_end) begin
        shift_q <= i_conv_result;
        bit_cnt_q <= 5'h00;
        read_done_q <= 1'b0;
        o_serial_out_line <= i_conv_result[RESULT_W-1];
      end else if (shift_en) begin
        // advance on falling edge; chain input shifts through in daisy mode, zero shifts in otherwise
        shift_q <= shift_next;
        bit_cnt_q <= bit_cnt_q + 5'h01;
        o_serial_out_line <= shift_next[RESULT_W-1];
        if (last_bit) begin
          read_done_q <= 1'b1;
        end
      end
      // release on select high or after last bit in chip-select mode; on start rise
      // drive while selected, MSB already on the line
      o_serial_out_oe <= (cs_drive || dc_drive) && !last_bit && !conv_end;
    end
  end

  // Configuration word write
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= '0;
      wr_cnt_q <= 5'h00;
      o_cfg_word <= '0;
      o_cfg_valid <= 1'b0;
    end else if (i_ce) begin
      o_cfg_valid <= 1'b0;
      if (start_rise) begin
        wr_cnt_q <= 5'h00;
      end else if (wr_en) begin
        wr_q <= {wr_q[CFG_W-2:0], pin_s.serial_in_line};
        if (wr_cnt_q == CFG_LAST) begin
          o_cfg_word <= {wr_q[CFG_W-2:0], pin_s.serial_in_line};
          o_cfg_valid <= 1'b1;
          wr_cnt_q <= 5'h00;
        end else begin
          wr_cnt_q <= wr_cnt_q + 5'h01;
        end
      end
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  a_conv_bound: assert property (o_conv_busy |-> conv_cnt_q <= CONV_LAST)
    else $error("conversion ran past its window");
  a_conv_done: assert property (i_ce && conv_end |=> !o_conv_busy && o_data_ready)
    else $error("conversion end not reported");
  a_mode_pick: assert property (i_ce && idle && start_rise |=>
    o_daisy_mode == !$past(pin_s.serial_in_line))
    else $error("mode not taken from serial input");
  a_start_release: assert property (i_ce && start_rise |=> !o_serial_out_oe)
    else $error("output still driven after start rise");
  a_select_drive: assert property (i_ce && cs_drive && !sclk_fall |=> o_serial_out_oe)
    else $error("selected output not driven");
  a_msb_first: assert property ($rose(o_serial_out_oe) && !o_daisy_mode && bit_cnt_q == 5'h00
    |-> o_serial_out_line == result_q[RESULT_W-1])
    else $error("first bit is not the MSB");
  a_fall_shift: assert property (i_ce && shift_en && !conv_end |=>
    o_serial_out_line == $past(shift_q[RESULT_W-2]))
    else $error("output did not advance on falling edge");
  a_last_release: assert property (i_ce && last_bit |=> !o_serial_out_oe [*2])
    else $error("output not released after last bit");
  a_acq_window: assert property (i_ce && conv_end |=> !o_acq_ready [*2])
    else $error("acquisition window not opened");

endmodule : acs_core
`default_nettype wire

/* File: logic/acs_pkg.sv */
// Shared constants and types for the converter serial timing block.
// Assumes a single 50 MHz core clock samples every pin of the host link.
package acs_pkg;

  localparam int CLK_PERIOD_NS = 20;

  // Conversion time window, measured from the detected start edge
  localparam int CONVERSION_TIME_MIN_NS = 300;
  localparam int CONVERSION_TIME_TYP_NS = 320;
  localparam int CONVERSION_TIME_MAX_NS = 350;
  localparam int CONV_MIN_CYC = (CONVERSION_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONVERSION_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam logic [4:0] CONV_LAST = 5'(CONV_MIN_CYC - 1);

  // Acquisition window per speed grade
  localparam int ACQ_FAST_NS = 325;
  localparam int ACQ_MID_NS = 770;
  localparam int ACQ_SLOW_NS = 1770;
  localparam logic [6:0] ACQ_FAST_CYC = 7'((ACQ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] ACQ_MID_CYC = 7'((ACQ_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] ACQ_SLOW_CYC = 7'((ACQ_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Host-side spacing figures the block relies on
  localparam int CYCLE_FAST_NS = 555;
  localparam int CYCLE_MID_NS = 1000;
  localparam int CYCLE_SLOW_NS = 2000;
  localparam int CONVERT_PULSE_WIDTH_NS = 10;
  localparam int QUIET_AFTER_CONVERT_NS = 200;
  localparam int QUIET_BEFORE_CONVERT_NS = 60;
  localparam int WRITE_SETUP_NS = 6;
  localparam int OUTPUT_RELEASE_DELAY_NS = 20;
  localparam int SCLK_MIN_CS_HI_PS = 9800;
  localparam int SCLK_MIN_CS_LO_PS = 12300;
  localparam int SCLK_MIN_DC_HI_NS = 20;
  localparam int SCLK_MIN_DC_LO_NS = 25;

  // Throughput limits, kSPS, chip-select mode
  localparam int TURBO_MIN_SCLK_MHZ = 71;
  localparam int TPUT_TURBO_KSPS = 1800;
  localparam int TPUT_TURBO_ST_100_KSPS = 1800;
  localparam int TPUT_TURBO_ST_80_KSPS = 1670;
  localparam int TPUT_PLAIN_100_KSPS = 1610;
  localparam int TPUT_PLAIN_80_KSPS = 1490;
  localparam int TPUT_PLAIN_ST_100_KSPS = 1470;
  localparam int TPUT_PLAIN_ST_80_KSPS = 1340;

  // Word sizes
  localparam int RESULT_W = 20;
  localparam int CFG_W = 16;
  localparam int CHAIN_DELAY = 20;
  localparam logic [4:0] RESULT_LAST = 5'(RESULT_W - 1);
  localparam logic [4:0] CFG_LAST = 5'(CFG_W - 1);

  localparam logic [1:0] GRADE_FAST = 2'h0;
  localparam logic [1:0] GRADE_MID = 2'h1;

  typedef struct packed {
    logic convert_start;
    logic serial_clk;
    logic serial_in_line;
  } acs_pins_t;

  typedef enum logic [0:0] {ST_IDLE, ST_CONV} acs_state_t;

endpackage : acs_pkg

/* File: logic/acs_sync.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to the core clock; freezes when i_ce is low.
`timescale 1ns/10ps
`default_nettype none
module acs_sync #(
  parameter int W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (i_ce) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : acs_sync
`default_nettype wire
